// ### prb_pkg.sv
// Constants, offsets and types of the port register bank
package prb_pkg;

  localparam int unsigned NUM_PORTS = 5;
  localparam int unsigned PORT_W    = 8;
  localparam int unsigned PAGE_W    = 4;

  // Port indices
  localparam int unsigned PA = 0;
  localparam int unsigned PB = 1;
  localparam int unsigned PC = 2;
  localparam int unsigned PD = 3;
  localparam int unsigned PE = 4;

  // Register offsets within the I/O select window, 8-bit mode
  localparam logic [7:0] OFS_A_IN    = 8'h00;
  localparam logic [7:0] OFS_B_IN    = 8'h01;
  localparam logic [7:0] OFS_A_MODE  = 8'h02;
  localparam logic [7:0] OFS_B_MODE  = 8'h03;
  localparam logic [7:0] OFS_A_OUT   = 8'h04;
  localparam logic [7:0] OFS_B_OUT   = 8'h05;
  localparam logic [7:0] OFS_A_DIR   = 8'h06;
  localparam logic [7:0] OFS_B_DIR   = 8'h07;
  localparam logic [7:0] OFS_A_OWN   = 8'h0a;
  localparam logic [7:0] OFS_B_OWN   = 8'h0b;
  localparam logic [7:0] OFS_A_CELL  = 8'h0c;
  localparam logic [7:0] OFS_B_CELL  = 8'h0d;
  localparam logic [7:0] OFS_C_IN    = 8'h10;
  localparam logic [7:0] OFS_D_IN    = 8'h11;
  localparam logic [7:0] OFS_C_MODE  = 8'h12;
  localparam logic [7:0] OFS_D_MODE  = 8'h13;
  localparam logic [7:0] OFS_C_OUT   = 8'h14;
  localparam logic [7:0] OFS_D_OUT   = 8'h15;
  localparam logic [7:0] OFS_C_DIR   = 8'h16;
  localparam logic [7:0] OFS_D_DIR   = 8'h17;
  localparam logic [7:0] OFS_C_DRV   = 8'h18;
  localparam logic [7:0] OFS_D_DRV   = 8'h19;
  localparam logic [7:0] OFS_E_IN    = 8'h20;
  localparam logic [7:0] OFS_E_MODE  = 8'h22;
  localparam logic [7:0] OFS_E_OUT   = 8'h24;
  localparam logic [7:0] OFS_E_DIR   = 8'h26;
  localparam logic [7:0] OFS_E_OWN   = 8'h2a;
  localparam logic [7:0] OFS_E_CELL  = 8'h2c;
  localparam logic [7:0] OFS_PSAVE0  = 8'hb0;
  localparam logic [7:0] OFS_PSAVE1  = 8'hb1;
  localparam logic [7:0] OFS_MEMCFG  = 8'hc0;
  localparam logic [7:0] OFS_PAGE    = 8'he0;

  // Memory configuration fields
  localparam int unsigned MEMCFG_SRAM_PROG_BIT = 0;
  localparam int unsigned MEMCFG_PERIPH_BIT    = 1;

  // Reset values and read value of unmapped offsets
  localparam logic [7:0]  REG_RESET  = 8'h00;
  localparam logic [3:0]  PAGE_RESET = 4'h0;
  localparam logic [7:0]  UNMAPPED   = 8'h00;

  // Timing
  localparam int unsigned CLK_PERIOD_NS          = 10;
  localparam int unsigned RESET_RELEASE_DELAY_NS = 100;
  localparam int unsigned RESET_RELEASE_CYCLES   =
    (RESET_RELEASE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int unsigned RST_CNT_W = 12;

  typedef enum logic [2:0] {
    RST_HOLD  = 3'b001,
    RST_DELAY = 3'b010,
    RUNNING   = 3'b100
  } prb_rst_state_t;

endpackage

// ### prb_port_bank.sv
// Port register bank with pin drive and reset sequencing
`timescale 1ns/1ns
module prb_port_bank #(
  parameter bit          HAS_PORT_E_CELLS = 1'b1,
  parameter int unsigned RELEASE_CYCLES   = prb_pkg::RESET_RELEASE_CYCLES
) (
  // Clock and reset
  input  wire logic                                         clock_i,
  input  wire logic                                         resetn_i,
  // Host register access
  input  wire logic                                         io_block_select_i,
  input  wire logic [7:0]                                   bus_addr_i,
  input  wire logic                                         bus_wr_i,
  input  wire logic                                         bus_rd_i,
  input  wire logic [7:0]                                   bus_wdata_i,
  input  wire logic                                         swap_mode_i,
  output logic      [7:0]                                   bus_rdata_o,
  // Mode
  input  wire logic                                         standby_i,
  // Pins
  input  wire logic [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] pin_in_i,
  output logic      [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] pin_out_o,
  output logic      [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] pin_oe_n_o,
  // Programmable logic side
  input  wire logic [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] logic_owned_i,
  input  wire logic [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] logic_out_i,
  input  wire logic [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] logic_oe_i,
  input  wire logic [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] addr_out_i,
  input  wire logic [prb_pkg::PORT_W-1:0]                   cell_out_a_i,
  input  wire logic [prb_pkg::PORT_W-1:0]                   cell_out_b_i,
  input  wire logic [prb_pkg::PORT_W-1:0]                   cell_out_e_i,
  // Peripheral I/O on port A
  input  wire logic [prb_pkg::PORT_W-1:0]                   periph_out_i,
  input  wire logic                                         periph_drive_i,
  // Macrocell clearing
  input  wire logic                                         cell_clear_term_i,
  input  wire logic                                         cell_clear_input_i,
  input  wire logic                                         cell_clear_enable_i,
  output logic                                              cell_clear_o,
  // Configuration outputs
  output logic      [prb_pkg::PAGE_W-1:0]                   page_o,
  output logic      [7:0]                                   power_saving_control_low_o,
  output logic      [7:0]                                   power_saving_control_high_o,
  output logic      [7:0]                                   memory_space_config_o,
  output logic                                              sram_as_program_o,
  output logic                                              in_reset_o
);

  typedef logic [prb_pkg::NUM_PORTS-1:0][prb_pkg::PORT_W-1:0] prb_ports_t;

  typedef struct packed {
    prb_pkg::prb_rst_state_t              rst;
    logic [prb_pkg::RST_CNT_W-1:0]        cnt;
    prb_ports_t                           sync1;
    prb_ports_t                           sync2;
    logic                                 stby1;
    logic                                 stby2;
    prb_ports_t                           mode;
    prb_ports_t                           dout;
    prb_ports_t                           dir;
    logic [1:0][prb_pkg::PORT_W-1:0]      drv;
    logic [prb_pkg::PAGE_W-1:0]           page;
    logic [7:0]                           psave0;
    logic [7:0]                           psave1;
    logic [7:0]                           memcfg;
    logic [7:0]                           rdata;
    prb_ports_t                           pout;
    prb_ports_t                           poen;
    logic                                 clr;
  } prb_state_t;

  prb_state_t state_ff;
  prb_state_t nxt_state;

  // Drive of one pin: returns {value, output enable low}
  function automatic logic [1:0] drive_bit(
    input logic rst,
    input logic stby,
    input logic own,
    input logic lo,
    input logic loe,
    input logic periph,
    input logic pdat,
    input logic pdrv,
    input logic mode,
    input logic dir,
    input logic dout,
    input logic od,
    input logic addr
  );
    logic val;
    logic oen;
    val = 1'b0;
    oen = 1'b1;
    if (own) begin
      val = lo;
      oen = ~loe;
    end else if (rst) begin
      oen = 1'b1;
    end else if (periph) begin
      val = pdat;
      oen = ~(pdrv & ~stby);
    end else if (mode) begin
      val = od ? 1'b0 : dout;
      oen = ~(dir & ~(od & dout));
    end else begin
      val = addr;
      oen = stby;
    end
    return {val, oen};
  endfunction

  logic [7:0] eff_addr;
  logic       in_reset;
  logic       acc_wr;
  logic       acc_rd;

  assign eff_addr = bus_addr_i ^ {7'h00, swap_mode_i};
  assign in_reset = (state_ff.rst != prb_pkg::RUNNING);
  assign acc_wr   = io_block_select_i & bus_wr_i;
  assign acc_rd   = io_block_select_i & bus_rd_i;

  always_comb begin
    logic [1:0] d;
    d         = 2'b00;
    nxt_state = state_ff;

    // Pin and standby synchronisers
    nxt_state.sync1 = pin_in_i;
    nxt_state.sync2 = state_ff.sync1;
    nxt_state.stby1 = standby_i;
    nxt_state.stby2 = state_ff.stby1;

    // Reset release sequence
    case (state_ff.rst)
      prb_pkg::RST_HOLD: begin
        nxt_state.rst = prb_pkg::RST_DELAY;
        nxt_state.cnt = '0;
      end
      prb_pkg::RST_DELAY: begin
        if (state_ff.cnt >= prb_pkg::RST_CNT_W'(RELEASE_CYCLES - 1)) begin
          nxt_state.rst = prb_pkg::RUNNING;
        end else begin
          nxt_state.cnt = state_ff.cnt + 1'b1;
        end
      end
      prb_pkg::RUNNING: begin
        nxt_state.cnt = '0;
      end
      default: begin
        nxt_state.rst = prb_pkg::RST_HOLD;
      end
    endcase

    // Register writes, accepted once out of reset
    if (acc_wr && !in_reset) begin
      case (eff_addr)
        prb_pkg::OFS_A_MODE: nxt_state.mode[prb_pkg::PA] = bus_wdata_i;
        prb_pkg::OFS_B_MODE: nxt_state.mode[prb_pkg::PB] = bus_wdata_i;
        prb_pkg::OFS_C_MODE: nxt_state.mode[prb_pkg::PC] = bus_wdata_i;
        prb_pkg::OFS_D_MODE: nxt_state.mode[prb_pkg::PD] = bus_wdata_i;
        prb_pkg::OFS_E_MODE: nxt_state.mode[prb_pkg::PE] = bus_wdata_i;
        prb_pkg::OFS_A_OUT:  nxt_state.dout[prb_pkg::PA] = bus_wdata_i;
        prb_pkg::OFS_B_OUT:  nxt_state.dout[prb_pkg::PB] = bus_wdata_i;
        prb_pkg::OFS_C_OUT:  nxt_state.dout[prb_pkg::PC] = bus_wdata_i;
        prb_pkg::OFS_D_OUT:  nxt_state.dout[prb_pkg::PD] = bus_wdata_i;
        prb_pkg::OFS_E_OUT:  nxt_state.dout[prb_pkg::PE] = bus_wdata_i;
        prb_pkg::OFS_A_DIR:  nxt_state.dir[prb_pkg::PA]  = bus_wdata_i;
        prb_pkg::OFS_B_DIR:  nxt_state.dir[prb_pkg::PB]  = bus_wdata_i;
        prb_pkg::OFS_C_DIR:  nxt_state.dir[prb_pkg::PC]  = bus_wdata_i;
        prb_pkg::OFS_D_DIR:  nxt_state.dir[prb_pkg::PD]  = bus_wdata_i;
        prb_pkg::OFS_E_DIR:  nxt_state.dir[prb_pkg::PE]  = bus_wdata_i;
        prb_pkg::OFS_C_DRV:  nxt_state.drv[0]            = bus_wdata_i;
        prb_pkg::OFS_D_DRV:  nxt_state.drv[1]            = bus_wdata_i;
        prb_pkg::OFS_PSAVE0: nxt_state.psave0            = bus_wdata_i;
        prb_pkg::OFS_PSAVE1: nxt_state.psave1            = bus_wdata_i;
        prb_pkg::OFS_MEMCFG: nxt_state.memcfg            = bus_wdata_i;
        prb_pkg::OFS_PAGE:   nxt_state.page = bus_wdata_i[prb_pkg::PAGE_W-1:0];
        default: begin
        end
      endcase
    end

    // Register reads, answered even during reset
    if (acc_rd) begin
      case (eff_addr)
        prb_pkg::OFS_A_IN:   nxt_state.rdata = state_ff.sync2[prb_pkg::PA];
        prb_pkg::OFS_B_IN:   nxt_state.rdata = state_ff.sync2[prb_pkg::PB];
        prb_pkg::OFS_C_IN:   nxt_state.rdata = state_ff.sync2[prb_pkg::PC];
        prb_pkg::OFS_D_IN:   nxt_state.rdata = state_ff.sync2[prb_pkg::PD];
        prb_pkg::OFS_E_IN:   nxt_state.rdata = state_ff.sync2[prb_pkg::PE];
        prb_pkg::OFS_A_MODE: nxt_state.rdata = state_ff.mode[prb_pkg::PA];
        prb_pkg::OFS_B_MODE: nxt_state.rdata = state_ff.mode[prb_pkg::PB];
        prb_pkg::OFS_C_MODE: nxt_state.rdata = state_ff.mode[prb_pkg::PC];
        prb_pkg::OFS_D_MODE: nxt_state.rdata = state_ff.mode[prb_pkg::PD];
        prb_pkg::OFS_E_MODE: nxt_state.rdata = state_ff.mode[prb_pkg::PE];
        prb_pkg::OFS_A_OUT:  nxt_state.rdata = state_ff.dout[prb_pkg::PA];
        prb_pkg::OFS_B_OUT:  nxt_state.rdata = state_ff.dout[prb_pkg::PB];
        prb_pkg::OFS_C_OUT:  nxt_state.rdata = state_ff.dout[prb_pkg::PC];
        prb_pkg::OFS_D_OUT:  nxt_state.rdata = state_ff.dout[prb_pkg::PD];
        prb_pkg::OFS_E_OUT:  nxt_state.rdata = state_ff.dout[prb_pkg::PE];
        prb_pkg::OFS_A_DIR:  nxt_state.rdata = state_ff.dir[prb_pkg::PA];
        prb_pkg::OFS_B_DIR:  nxt_state.rdata = state_ff.dir[prb_pkg::PB];
        prb_pkg::OFS_C_DIR:  nxt_state.rdata = state_ff.dir[prb_pkg::PC];
        prb_pkg::OFS_D_DIR:  nxt_state.rdata = state_ff.dir[prb_pkg::PD];
        prb_pkg::OFS_E_DIR:  nxt_state.rdata = state_ff.dir[prb_pkg::PE];
        prb_pkg::OFS_C_DRV:  nxt_state.rdata = state_ff.drv[0];
        prb_pkg::OFS_D_DRV:  nxt_state.rdata = state_ff.drv[1];
        prb_pkg::OFS_A_OWN:  nxt_state.rdata = logic_owned_i[prb_pkg::PA];
        prb_pkg::OFS_B_OWN:  nxt_state.rdata = logic_owned_i[prb_pkg::PB];
        prb_pkg::OFS_E_OWN:  nxt_state.rdata = logic_owned_i[prb_pkg::PE];
        prb_pkg::OFS_A_CELL: nxt_state.rdata = cell_out_a_i;
        prb_pkg::OFS_B_CELL: nxt_state.rdata = cell_out_b_i;
        prb_pkg::OFS_E_CELL: nxt_state.rdata = HAS_PORT_E_CELLS ? cell_out_e_i : prb_pkg::UNMAPPED;
        prb_pkg::OFS_PSAVE0: nxt_state.rdata = state_ff.psave0;
        prb_pkg::OFS_PSAVE1: nxt_state.rdata = state_ff.psave1;
        prb_pkg::OFS_MEMCFG: nxt_state.rdata = state_ff.memcfg;
        prb_pkg::OFS_PAGE:   nxt_state.rdata = {4'h0, state_ff.page};
        default:             nxt_state.rdata = prb_pkg::UNMAPPED;
      endcase
    end

    // Pin drive per bit
    for (int p = 0; p < prb_pkg::NUM_PORTS; p++) begin
      for (int b = 0; b < prb_pkg::PORT_W; b++) begin
        d = drive_bit(
          in_reset,
          state_ff.stby2,
          logic_owned_i[p][b],
          logic_out_i[p][b],
          logic_oe_i[p][b],
          (p == prb_pkg::PA) && state_ff.memcfg[prb_pkg::MEMCFG_PERIPH_BIT],
          periph_out_i[b],
          periph_drive_i,
          state_ff.mode[p][b],
          state_ff.dir[p][b],
          state_ff.dout[p][b],
          (p == prb_pkg::PC) ? state_ff.drv[0][b] :
            ((p == prb_pkg::PD) ? state_ff.drv[1][b] : 1'b0),
          addr_out_i[p][b]
        );
        nxt_state.pout[p][b] = d[1];
        nxt_state.poen[p][b] = d[0];
      end
    end

    // Macrocell flop clear
    nxt_state.clr = cell_clear_term_i | (cell_clear_enable_i & cell_clear_input_i);
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_ff.rst    <= prb_pkg::RST_HOLD;
      state_ff.cnt    <= '0;
      state_ff.sync1  <= '0;
      state_ff.sync2  <= '0;
      state_ff.stby1  <= 1'b0;
      state_ff.stby2  <= 1'b0;
      state_ff.mode   <= {prb_pkg::NUM_PORTS{prb_pkg::REG_RESET}};
      state_ff.dout   <= {prb_pkg::NUM_PORTS{prb_pkg::REG_RESET}};
      state_ff.dir    <= {prb_pkg::NUM_PORTS{prb_pkg::REG_RESET}};
      state_ff.drv    <= {2{prb_pkg::REG_RESET}};
      state_ff.page   <= prb_pkg::PAGE_RESET;
      state_ff.psave0 <= prb_pkg::REG_RESET;
      state_ff.psave1 <= prb_pkg::REG_RESET;
      state_ff.memcfg <= prb_pkg::REG_RESET;
      state_ff.rdata  <= prb_pkg::REG_RESET;
      state_ff.pout   <= '0;
      state_ff.poen   <= '1;
      state_ff.clr    <= 1'b0;
    end else begin
      state_ff <= nxt_state;
    end
  end

  assign bus_rdata_o                 = state_ff.rdata;
  assign pin_out_o                   = state_ff.pout;
  assign pin_oe_n_o                  = state_ff.poen;
  assign cell_clear_o                = state_ff.clr;
  assign page_o                      = state_ff.page;
  assign power_saving_control_low_o  = state_ff.psave0;
  assign power_saving_control_high_o = state_ff.psave1;
  assign memory_space_config_o       = state_ff.memcfg;
  assign sram_as_program_o           = state_ff.memcfg[prb_pkg::MEMCFG_SRAM_PROG_BIT];
  assign in_reset_o                  = in_reset;

endmodule

// ### prb_port_bank_asserts.sv
// Concurrent checks on the port register bank ports
`timescale 1ns/1ns
module prb_port_bank_asserts #(
  parameter int unsigned RELEASE_CYCLES = prb_pkg::RESET_RELEASE_CYCLES
) (
  // Clock and reset
  input wire logic             clock_i,
  input wire logic             resetn_i,
  // Host register access
  input wire logic             io_block_select_i,
  input wire logic [7:0]       bus_addr_i,
  input wire logic             bus_wr_i,
  input wire logic             bus_rd_i,
  input wire logic [7:0]       bus_wdata_i,
  input wire logic             swap_mode_i,
  input wire logic [7:0]       bus_rdata_o,
  // Pins and logic side
  input wire logic [4:0][7:0]  pin_oe_n_o,
  input wire logic [4:0][7:0]  logic_owned_i,
  input wire logic [7:0]       cell_out_b_i,
  input wire logic [7:0]       cell_out_e_i,
  // Macrocell clearing
  input wire logic             cell_clear_term_i,
  input wire logic             cell_clear_input_i,
  input wire logic             cell_clear_enable_i,
  input wire logic             cell_clear_o,
  // Configuration outputs
  input wire logic [3:0]       page_o,
  input wire logic [7:0]       power_saving_control_high_o,
  input wire logic [7:0]       memory_space_config_o,
  input wire logic             sram_as_program_o,
  input wire logic             in_reset_o
);
  logic [7:0]  eff_addr;
  logic [15:0] rst_cnt_ff;
  logic [15:0] nxt_rst_cnt;
  assign eff_addr = bus_addr_i ^ {7'h00, swap_mode_i};
  always_comb begin
    nxt_rst_cnt = rst_cnt_ff + {15'h0000, in_reset_o};
  end
  always_ff @(posedge clock_i) begin
    if (!resetn_i) rst_cnt_ff <= 16'h0000;
    else rst_cnt_ff <= nxt_rst_cnt;
  end
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  sequence s_wr(logic [7:0] ofs);
    !in_reset_o && io_block_select_i && bus_wr_i && eff_addr == ofs;
  endsequence
  sequence s_rd(logic [7:0] ofs);
    !in_reset_o && io_block_select_i && bus_rd_i && eff_addr == ofs;
  endsequence
  a_page_load: assert property (s_wr(prb_pkg::OFS_PAGE) |=> {4'h0, page_o} == ($past(bus_wdata_i) & 8'h0f))
    else $error("Page register missed a write");
  a_memcfg_load: assert property (s_wr(prb_pkg::OFS_MEMCFG) |=> memory_space_config_o == $past(bus_wdata_i)
    ##0 sram_as_program_o == memory_space_config_o[0])
    else $error("Memory config write wrong");
  a_psave_load: assert property (s_wr(prb_pkg::OFS_PSAVE1) |=> power_saving_control_high_o == $past(bus_wdata_i))
    else $error("Power saving write wrong");
  a_cell_read: assert property (s_rd(prb_pkg::OFS_B_CELL) |=> bus_rdata_o == $past(cell_out_b_i))
    else $error("Cell output read wrong");
  a_cell_e_read: assert property (s_rd(prb_pkg::OFS_E_CELL) |=> bus_rdata_o == $past(cell_out_e_i))
    else $error("Port E cell read wrong");
  a_unmapped_read: assert property (s_rd(8'h08) |=> bus_rdata_o == prb_pkg::UNMAPPED)
    else $error("Unmapped read not zero");
  a_desel_quiet: assert property (!io_block_select_i |=> $stable(bus_rdata_o) && $stable(page_o))
    else $error("Change without select");
  a_reset_wr_drop: assert property (in_reset_o && io_block_select_i && bus_wr_i |=> $stable(page_o))
    else $error("Write taken during reset");
  a_reset_clears: assert property (disable iff (1'b0) !resetn_i |=> page_o == 4'h0
    && memory_space_config_o == 8'h00 && power_saving_control_high_o == 8'h00)
    else $error("Registers not cleared by reset");
  a_reset_tri: assert property ($past(in_reset_o) |-> &(pin_oe_n_o | $past(logic_owned_i)))
    else $error("Pin driven during reset");
  a_release_time: assert property ($fell(in_reset_o) |-> rst_cnt_ff == RELEASE_CYCLES + 1)
    else $error("Reset release delay wrong");
  a_release_bound: assert property (in_reset_o |-> rst_cnt_ff <= RELEASE_CYCLES)
    else $error("Reset release too late");
  a_clear_follow: assert property (resetn_i |=> cell_clear_o == ($past(cell_clear_term_i)
    | ($past(cell_clear_enable_i) & $past(cell_clear_input_i))))
    else $error("Cell clear wrong");
endmodule
bind prb_port_bank prb_port_bank_asserts #(.RELEASE_CYCLES(RELEASE_CYCLES)) u_asserts (
  .clock_i, .resetn_i, .io_block_select_i, .bus_addr_i, .bus_wr_i, .bus_rd_i, .bus_wdata_i,
  .swap_mode_i, .bus_rdata_o, .pin_oe_n_o, .logic_owned_i, .cell_out_b_i, .cell_out_e_i,
  .cell_clear_term_i, .cell_clear_input_i, .cell_clear_enable_i, .cell_clear_o, .page_o,
  .power_saving_control_high_o, .memory_space_config_o, .sram_as_program_o, .in_reset_o
);

// ### prb_host_model.sv
// Host bus model issuing byte register cycles
`timescale 1ns/1ns
module prb_host_model (
  // Clock
  input  wire logic       clock_i,
  // Register bus
  output logic            sel_o,
  output logic [7:0]      addr_o,
  output logic            wr_o,
  output logic            rd_o,
  output logic [7:0]      wdata_o,
  output logic            swap_o,
  input  wire logic [7:0] rdata_i
);
  initial begin
    {sel_o, wr_o, rd_o, swap_o} = 4'h0;
    addr_o = 8'h00;
    wdata_o = 8'h00;
  end
  task automatic set_swap(input logic v);
    @(posedge clock_i);
    swap_o <= v;
  endtask
  task automatic cycle(input logic [7:0] ofs, input logic w, input logic [7:0] d);
    @(posedge clock_i);
    sel_o <= 1'b1;
    wr_o <= w;
    rd_o <= !w;
    addr_o <= ofs ^ {7'h00, swap_o};
    wdata_o <= d;
    @(posedge clock_i);
    sel_o <= 1'b0;
    wr_o <= 1'b0;
    rd_o <= 1'b0;
    addr_o <= ~addr_o;
    wdata_o <= ~wdata_o;
  endtask
  task automatic write_reg(input logic [7:0] ofs, input logic [7:0] d);
    cycle(ofs, 1'b1, d);
  endtask
  task automatic read_reg(input logic [7:0] ofs, output logic [7:0] d);
    cycle(ofs, 1'b0, 8'h00);
    #1 d = rdata_i;
  endtask
endmodule

// ### tb_top.sv
// Self-checking bench for the port register bank
`timescale 1ns/1ns
module tb_top;
  logic            clock_i = 1'b0;
  logic            resetn_i = 1'b0;
  logic            standby = 1'b0;
  logic            sel, bus_wr, bus_rd, swap, pdrv = 1'b0, clr_t = 1'b0, clr_i = 1'b0, clr_e = 1'b0;
  logic            clr_o, sram_prog, in_reset;
  logic [7:0]      addr, wdata, rdata, ps_lo, ps_hi, memcfg;
  logic [7:0]      cell_a = 8'h00, cell_b = 8'h00, cell_e = 8'h00, pout = 8'h00;
  logic [3:0]      page;
  logic [4:0][7:0] pin_in = '0, own = '0, lout = '0, loe = '0, aout = '0, pin_out, oe_n;
  int              exp_reg [256];
  bit              is_rw [256];
  bit              model_rst = 1'b1;
  int              seed = 27;
  int              fail_count = 0;
  int              comparisons = 0;
  int              mo [5] = '{8'h02, 8'h03, 8'h12, 8'h13, 8'h22};
  int              rw_ofs [$] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'h12, 8'h13, 8'h14, 8'h15,
                                  8'h16, 8'h17, 8'h18, 8'h19, 8'h22, 8'h24, 8'h26, 8'hb0, 8'hb1, 8'hc0, 8'he0};
  int              rx_ofs [$] = '{8'h00, 8'h01, 8'h0a, 8'h0b, 8'h0c, 8'h0d, 8'h10, 8'h11, 8'h20, 8'h2a, 8'h2c,
                                  8'h08, 8'h0e, 8'h30, 8'hff};
  always #5 clock_i = ~clock_i;
  prb_host_model u_host (.clock_i(clock_i), .sel_o(sel), .addr_o(addr), .wr_o(bus_wr), .rd_o(bus_rd),
    .wdata_o(wdata), .swap_o(swap), .rdata_i(rdata));
  prb_port_bank #(.RELEASE_CYCLES(6)) DUT (.clock_i(clock_i), .resetn_i(resetn_i), .io_block_select_i(sel),
    .bus_addr_i(addr), .bus_wr_i(bus_wr), .bus_rd_i(bus_rd), .bus_wdata_i(wdata), .swap_mode_i(swap),
    .bus_rdata_o(rdata), .standby_i(standby), .pin_in_i(pin_in), .pin_out_o(pin_out), .pin_oe_n_o(oe_n),
    .logic_owned_i(own), .logic_out_i(lout), .logic_oe_i(loe), .addr_out_i(aout), .cell_out_a_i(cell_a),
    .cell_out_b_i(cell_b), .cell_out_e_i(cell_e), .periph_out_i(pout), .periph_drive_i(pdrv),
    .cell_clear_term_i(clr_t), .cell_clear_input_i(clr_i), .cell_clear_enable_i(clr_e), .cell_clear_o(clr_o),
    .page_o(page), .power_saving_control_low_o(ps_lo), .power_saving_control_high_o(ps_hi),
    .memory_space_config_o(memcfg), .sram_as_program_o(sram_prog), .in_reset_o(in_reset));
  always @(posedge clock_i) begin
    {clr_t, clr_i, clr_e} <= 3'($random(seed));
  end
  task automatic report_and_stop();
    if (fail_count == 0 && comparisons > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic chk(input string name, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      fail_count++;
      $display("Error %s expected %h seen %h", name, e, g);
    end
  endtask
  function automatic logic [7:0] exp_read(input int o);
    case (o)
      8'h00, 8'h01: return pin_in[o];
      8'h10, 8'h11: return pin_in[o - 14];
      8'h20: return pin_in[4];
      8'h0a, 8'h0b: return own[o - 10];
      8'h2a: return own[4];
      8'h0c: return cell_a;
      8'h0d: return cell_b;
      8'h2c: return cell_e;
      default: return 8'(exp_reg[o]);
    endcase
  endfunction
  task automatic wr(input int o, input logic [7:0] d);
    u_host.write_reg(8'(o), d);
    if (!model_rst && is_rw[o]) exp_reg[o] = (o == 8'he0) ? d & 8'h0f : d;
  endtask
  task automatic rd(input int o);
    logic [7:0] d;
    u_host.read_reg(8'(o), d);
    chk($sformatf("rdata_%h", o), exp_read(o), d);
  endtask
  task automatic wait_ready();
    for (int n = 0; n < 100 && in_reset !== 1'b0; n++) @(posedge clock_i);
    #1 model_rst = 1'b0;
    chk("in_reset_o", 8'h00, {7'h00, in_reset});
  endtask
  task automatic check_pins();
    logic [7:0] eo, ev;
    logic [0:0] m, dr, dt, od;
    for (int p = 0; p < 5; p++) begin
      for (int b = 0; b < 8; b++) begin
        {m, dr, dt} = {exp_reg[mo[p]][b], exp_reg[mo[p] + 4][b], exp_reg[mo[p] + 2][b]};
        od = (p == 2 || p == 3) ? exp_reg[8'h16 + p][b] : 0;
        if (own[p][b]) {eo[b], ev[b]} = {~loe[p][b], lout[p][b]};
        else if (model_rst) {eo[b], ev[b]} = 2'b10;
        else if (p == 0 && exp_reg[8'hc0][1]) {eo[b], ev[b]} = {~pdrv | standby, pout[b]};
        else if (m && dr) {eo[b], ev[b]} = od ? {dt[0], 1'b0} : {1'b0, dt[0]};
        else if (m) {eo[b], ev[b]} = 2'b10;
        else {eo[b], ev[b]} = {standby, aout[p][b]};
      end
      chk("pin_oe_n_o", eo, oe_n[p]);
      chk("pin_out_o", ev & ~eo, pin_out[p] & ~eo);
    end
  endtask
  initial begin
    foreach (rw_ofs[k]) is_rw[rw_ofs[k]] = 1'b1;
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    wr(8'he0, 8'h05);
    rd(8'h00);
    wait_ready();
    foreach (rw_ofs[k]) rd(rw_ofs[k]);
    for (int it = 0; it < 12; it++) begin
      u_host.set_swap(1'($random(seed)));
      foreach (rw_ofs[k]) wr(rw_ofs[k], 8'($random(seed)));
      wr(8'h00, 8'hff);
      wr(8'h08, 8'hff);
      pin_in <= 40'({$random(seed), $random(seed)});
      own <= 40'({$random(seed), $random(seed)}) & 40'({$random(seed), $random(seed)});
      {lout, loe, aout} <= 120'({$random(seed), $random(seed), $random(seed), $random(seed)});
      {cell_a, cell_b, cell_e, pout, pdrv, standby} <= 34'({$random(seed), $random(seed)});
      repeat (4) @(posedge clock_i);
      foreach (rw_ofs[k]) rd(rw_ofs[k]);
      foreach (rx_ofs[k]) rd(rx_ofs[k]);
      chk("page_o", 8'(exp_reg[8'he0]), {4'h0, page});
      chk("power_saving_control_low_o", 8'(exp_reg[8'hb0]), ps_lo);
      chk("power_saving_control_high_o", 8'(exp_reg[8'hb1]), ps_hi);
      chk("memory_space_config_o", 8'(exp_reg[8'hc0]), memcfg);
      chk("sram_as_program_o", {7'h00, exp_reg[8'hc0][0]}, {7'h00, sram_prog});
      check_pins();
    end
    @(posedge clock_i);
    resetn_i <= 1'b0;
    model_rst = 1'b1;
    foreach (rw_ofs[k]) exp_reg[rw_ofs[k]] = 0;
    repeat (8) @(posedge clock_i);
    resetn_i <= 1'b1;
    repeat (3) @(posedge clock_i);
    #1 check_pins();
    wait_ready();
    foreach (rw_ofs[k]) rd(rw_ofs[k]);
    report_and_stop();
  end
  initial begin
    #300000;
    fail_count++;
    report_and_stop();
  end
endmodule
